/* design/ctcl_pkg.sv */
package ctcl_pkg;
	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 3; // Register index width
	localparam int DATA_W = 8; // Register data width
	localparam logic [2:0] CTRL_OFS = 3'h0; // Timer control register
	localparam logic [2:0] STAT_OFS = 3'h1; // Timer status register
	localparam logic [2:0] CNT_HIGH_OFS = 3'h2; // Upper counter
	localparam logic [2:0] CNT_LOW_OFS = 3'h3; // Lower counter
	localparam logic [2:0] CMP_HIGH_OFS = 3'h4; // Upper compare register
	localparam logic [2:0] CMP_LOW_OFS = 3'h5; // Lower compare register
	localparam logic [2:0] IRQ_OFS = 3'h6; // Request and enable bits

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00; // Control after reset
	localparam logic [7:0] STAT_RST = 8'h00; // Status after reset
	localparam logic [7:0] CNT_RST = 8'h00; // Counter halves after reset
	localparam logic [7:0] CMP_RST = 8'hff; // Compare halves after reset
	localparam logic [3:0] IRQ_RST = 4'h0; // Requests and enables
	localparam logic [7:0] UNMAPPED_DATA = 8'h00; // Read of a hole

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_LVL_HIGH_BIT = 7; // out_level_high_bit
	localparam int CTRL_SPLIT_BIT = 6; // split_mode_select
	localparam int CTRL_SELH_LSB = 4; // Upper clock select, two bits
	localparam int CTRL_LVL_LOW_BIT = 3; // out_level_low_bit
	localparam int CTRL_RUNL_BIT = 2; // Lower clock run bit
	localparam int CTRL_SELL_LSB = 0; // Lower clock select, two bits

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_WRAPH_BIT = 7; // wrap_flag_high
	localparam int STAT_MATCHH_BIT = 6; // match_flag_high
	localparam int STAT_OVIEH_BIT = 5; // Upper wrap request enable
	localparam int STAT_CLRH_BIT = 4; // clear_on_match_high
	localparam int STAT_WRAPL_BIT = 3; // wrap_flag_low
	localparam int STAT_MATCHL_BIT = 2; // match_flag_low
	localparam int STAT_OVIEL_BIT = 1; // Lower wrap request enable
	localparam int STAT_CLRL_BIT = 0; // Lower clear on match

	// ----------------------------------------------------------------
	// Request register fields
	// ----------------------------------------------------------------
	localparam int IRQ_REQL_BIT = 0; // irq_request_low
	localparam int IRQ_REQH_BIT = 1; // irq_request_high
	localparam int IRQ_ENL_BIT = 2; // irq_enable_low
	localparam int IRQ_ENH_BIT = 3; // irq_enable_high

	// ----------------------------------------------------------------
	// Count sources and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_WATCH4 = 2'h0; // Watch clock / 4
	localparam logic [1:0] SEL_SYS4 = 2'h1; // System clock / 4
	localparam logic [1:0] SEL_SYS16 = 2'h2; // System clock / 16
	localparam logic [1:0] SEL_SYS32 = 2'h3; // System clock / 32
	localparam logic [1:0] DIV4_LAST = 2'h3; // Last prescaler step, /4
	localparam logic [3:0] DIV16_LAST = 4'hf; // Last prescaler step, /16
	localparam logic [4:0] DIV32_LAST = 5'h1f; // Last prescaler step, /32
	localparam logic [1:0] WATCH_DIV_LAST = 2'h3; // Watch divide by 4
	localparam logic [1:0] SIG_WATCH_CYCLES = 2'h2; // Match/wrap width
	localparam logic [1:0] SRC_WATCH_CYCLES = 2'h1; // Source signal width
	localparam logic [7:0] HALF_MAX = 8'hff; // Wrap point of a half
endpackage

/* design/ctcl_tick_gen.sv */
`timescale 1ns/1ns
// Count tick and event stretching for one counter half
module ctcl_tick_gen (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic runEn,
	input wire logic [1:0] clkSel,
	input wire logic [4:0] prescCount,
	input wire logic watchEdge,
	input wire logic watchQuarter,
	input wire logic matchEvent,
	input wire logic wrapEvent,
	input wire logic srcEvent,
	output logic tick,
	output logic fromWatch,
	output logic matchActive,
	output logic wrapActive,
	output logic srcActive
);
	import ctcl_pkg::*;

	logic [1:0] matchHold_reg; // Watch edges left on match signal
	logic [1:0] wrapHold_reg; // Watch edges left on wrap signal
	logic [1:0] srcHold_reg; // Watch edges left on source signal

	// ----------------------------------------------------------------
	// Tick selection
	// ----------------------------------------------------------------
	// One system cycle pulse per count, none while stopped
	always_comb begin
		fromWatch = (clkSel == SEL_WATCH4);
		tick = 1'b0;
		if (runEn) begin
			case (clkSel)
				SEL_WATCH4: tick = watchQuarter;
				SEL_SYS4: tick = (prescCount[1:0] == DIV4_LAST);
				SEL_SYS16: tick = (prescCount[3:0] == DIV16_LAST);
				default: tick = (prescCount == DIV32_LAST);
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Stretching in watch cycles
	// ----------------------------------------------------------------
	// Match and wrap signals stand two watch cycles on the watch source
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			matchHold_reg <= 2'h0;
			wrapHold_reg <= 2'h0;
		end else begin
			if (matchEvent && fromWatch) begin
				matchHold_reg <= SIG_WATCH_CYCLES;
			end else if (watchEdge && matchHold_reg != 2'h0) begin
				matchHold_reg <= matchHold_reg - 2'h1;
			end
			if (wrapEvent && fromWatch) begin
				wrapHold_reg <= SIG_WATCH_CYCLES;
			end else if (watchEdge && wrapHold_reg != 2'h0) begin
				wrapHold_reg <= wrapHold_reg - 2'h1;
			end
		end
	end

	// Source signal stands one watch cycle on the watch source
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			srcHold_reg <= 2'h0;
		end else if (srcEvent && fromWatch) begin
			srcHold_reg <= SRC_WATCH_CYCLES;
		end else if (watchEdge && srcHold_reg != 2'h0) begin
			srcHold_reg <= srcHold_reg - 2'h1;
		end
	end

	// Active in the event cycle and while the hold runs
	always_comb begin
		matchActive = matchEvent || (matchHold_reg != 2'h0);
		wrapActive = wrapEvent || (wrapHold_reg != 2'h0);
		srcActive = srcEvent || (srcHold_reg != 2'h0);
	end
endmodule // ctcl_tick_gen

/* design/ctcl_timer.sv */
`timescale 1ns/1ns
// Contract
// - 16-bit mode: high pin toggles on full match
// - Control write beats toggle; level bit wins
// - Compare write discards coinciding match
// - Match only on a count tick
// - High flag full match; low flag low match
// - High wrap on full wrap; low on low wrap
// - Counter write suppresses coinciding wrap
// - Source signal one watch cycle wide
// - Match and wrap signals two watch cycles
// - Active-mode request clear fails while source valid
// - Active-mode flag clear fails while signal valid
// - Subactive mode: clears take effect while signal valid
// - Active watch-source counter write not loaded
// - Active watch-source reads via synchroniser
// - Subactive mode: exact counter reads, writes
// - Split bit: two 8-bit or one 16-bit
// - Match in last equal state, at tick
// - Clear bit resets counter on match
// - Flags clear by 0 after read as 1
module ctcl_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [ctcl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ctcl_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic watchClk,
	input wire logic subactiveMode,
	output logic [ctcl_pkg::DATA_W-1:0] regRdData,
	output logic toggle_out_high_pin,
	output logic toggle_out_low_pin,
	output logic irqHigh,
	output logic irqLow
);
	import ctcl_pkg::*;
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] timer_control_reg; // Levels, split and clock selects
	logic [7:0] timer_status_reg; // Flags, enables, clear bits
	logic [7:0] upper_counter, lower_counter; // Halves of full_counter
	logic [7:0] upper_compare_reg, lower_compare_reg; // Compare values
	logic [3:0] irq_reg; // Request flags and enables
	logic [7:0] statArm_reg; // Flags seen as 1 by a status read
	logic [15:0] cntShadow_reg; // Synchronised counter copy
	logic [4:0] presc_reg; // System clock prescaler
	logic watchPrev_reg; // Watch clock level one cycle back
	logic [1:0] watchDiv_reg; // Watch clock divide by four
	logic [15:0] full_counter; // Both halves together
	logic watchEdge, watchQuarter; // Watch rising edge, every fourth one
	logic split; // Two independent halves
	logic [1:0] tick; // Count ticks, [1] upper, [0] lower
	logic [1:0] fromWatch; // Half counts on watch source
	logic [1:0] matchEvent, wrapEvent, srcEvent; // Raw events per half
	logic [1:0] matchActive, wrapActive, srcActive; // Stretched events
	logic [1:0] runEn; // Half clock running
	logic [3:0] clkSelBits; // Clock select seen by each half
	logic tickHigh; // Tick that moves the upper half
	logic wrCtrl, wrStat, wrIrq; // Control, status and request writes
	logic wrCntH, wrCntL, wrCmpH, wrCmpL; // Counter and compare writes
	logic [1:0] activeWatch; // Half on watch source in active mode
	logic [7:0] lowerNext, upperNext; // Counter next values
	logic [7:0] readMux; // Read data before the register

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// One strobe selects one register
	always_comb begin
		wrCtrl = regWrStb && (regAddr == CTRL_OFS);
		wrStat = regWrStb && (regAddr == STAT_OFS);
		wrCntH = regWrStb && (regAddr == CNT_HIGH_OFS);
		wrCntL = regWrStb && (regAddr == CNT_LOW_OFS);
		wrCmpH = regWrStb && (regAddr == CMP_HIGH_OFS);
		wrCmpL = regWrStb && (regAddr == CMP_LOW_OFS);
		wrIrq = regWrStb && (regAddr == IRQ_OFS);
	end
	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// Prescaler and watch clock divider
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			presc_reg <= 5'h00;
			watchPrev_reg <= 1'b0;
			watchDiv_reg <= 2'h0;
		end else begin
			presc_reg <= presc_reg + 5'h01;
			watchPrev_reg <= watchClk;
			if (watchEdge) begin
				watchDiv_reg <= watchDiv_reg + 2'h1;
			end
		end
	end

	// Edge and quarter pulses of the watch clock
	always_comb begin
		watchEdge = watchClk && !watchPrev_reg;
		watchQuarter = watchEdge && (watchDiv_reg == WATCH_DIV_LAST);
		split = timer_control_reg[CTRL_SPLIT_BIT];
		runEn[0] = timer_control_reg[CTRL_RUNL_BIT];
		runEn[1] = split;
		clkSelBits[1:0] = timer_control_reg[CTRL_SELL_LSB +: 2];
		// In 16-bit mode the upper events follow the lower source
		clkSelBits[3:2] = split ? timer_control_reg[CTRL_SELH_LSB +: 2]
			: timer_control_reg[CTRL_SELL_LSB +: 2];
		full_counter = {upper_counter, lower_counter};
	end

	// Tick and signal stretch for each half
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gHalf
			ctcl_tick_gen uTick (
				.ref_clk(ref_clk),
				.rst(rst),
				.runEn(runEn[gi]),
				.clkSel(clkSelBits[2*gi +: 2]),
				.prescCount(presc_reg),
				.watchEdge(watchEdge),
				.watchQuarter(watchQuarter),
				.matchEvent(matchEvent[gi]),
				.wrapEvent(wrapEvent[gi]),
				.srcEvent(srcEvent[gi]),
				.tick(tick[gi]),
				.fromWatch(fromWatch[gi]),
				.matchActive(matchActive[gi]),
				.wrapActive(wrapActive[gi]),
				.srcActive(srcActive[gi])
			);
		end
	endgenerate
	// ----------------------------------------------------------------
	// Match and wrap signals
	// ----------------------------------------------------------------
	// Events only on a tick, in the last state of equality
	always_comb begin
		tickHigh = split ? tick[1] : tick[0];
		// Lower half compares its own eight bits in both modes
		matchEvent[0] = tick[0] && (lower_counter == lower_compare_reg)
			&& !wrCmpL;
		wrapEvent[0] = tick[0] && (lower_counter == HALF_MAX)
			&& !wrCntL;
		if (split) begin
			matchEvent[1] = tick[1]
				&& (upper_counter == upper_compare_reg)
				&& !wrCmpH;
			wrapEvent[1] = tick[1] && (upper_counter == HALF_MAX)
				&& !wrCntH;
		end else begin
			matchEvent[1] = tick[0]
				&& (full_counter == {upper_compare_reg, lower_compare_reg})
				&& !wrCmpH && !wrCmpL;
			wrapEvent[1] = tick[0] && (full_counter == {HALF_MAX, HALF_MAX})
				&& !wrCntH && !wrCntL;
		end
		// Request source: match, or wrap when its enable is set
		srcEvent[0] = matchEvent[0]
			|| (wrapEvent[0] && timer_status_reg[STAT_OVIEL_BIT]);
		srcEvent[1] = matchEvent[1]
			|| (wrapEvent[1] && timer_status_reg[STAT_OVIEH_BIT]);
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Next values of both halves
	always_comb begin
		activeWatch = fromWatch & {2{!subactiveMode}};
		lowerNext = lower_counter;
		upperNext = upper_counter;
		if (split) begin
			// Two independent halves, each with its own clear bit
			if (tick[0]) begin
				if (matchEvent[0] && timer_status_reg[STAT_CLRL_BIT]) begin
					lowerNext = CNT_RST;
				end else begin
					lowerNext = lower_counter + 8'h01;
				end
			end
			if (tickHigh) begin
				if (matchEvent[1] && timer_status_reg[STAT_CLRH_BIT]) begin
					upperNext = CNT_RST;
				end else begin
					upperNext = upper_counter + 8'h01;
				end
			end
		end else if (tick[0]) begin
			// One 16-bit counter cleared by the full match
			if (matchEvent[1] && timer_status_reg[STAT_CLRH_BIT]) begin
				lowerNext = CNT_RST;
				upperNext = CNT_RST;
			end else begin
				lowerNext = lower_counter + 8'h01;
				if (lower_counter == HALF_MAX) begin
					upperNext = upper_counter + 8'h01;
				end
			end
		end
		if (wrCntL && !activeWatch[0]) begin
			lowerNext = regWrData;
		end
		if (wrCntH && !activeWatch[1]) begin
			upperNext = regWrData;
		end
	end

	// Counter halves and their synchronised copy
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			upper_counter <= CNT_RST;
			lower_counter <= CNT_RST;
			cntShadow_reg <= {CNT_RST, CNT_RST};
		end else begin
			upper_counter <= upperNext;
			lower_counter <= lowerNext;
			cntShadow_reg <= full_counter;
		end
	end

	// ----------------------------------------------------------------
	// Control and compare registers
	// ----------------------------------------------------------------
	// Plain software registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_control_reg <= CTRL_RST;
			upper_compare_reg <= CMP_RST;
			lower_compare_reg <= CMP_RST;
		end else begin
			if (wrCtrl) begin
				timer_control_reg <= regWrData;
			end
			if (wrCmpH) begin
				upper_compare_reg <= regWrData;
			end
			if (wrCmpL) begin
				lower_compare_reg <= regWrData;
			end
		end
	end

	// ----------------------------------------------------------------
	// Toggle outputs
	// ----------------------------------------------------------------
	// A control write loads the level bit and beats a toggle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			toggle_out_high_pin <= 1'b0;
			toggle_out_low_pin <= 1'b0;
		end else begin
			if (wrCtrl) begin
				toggle_out_high_pin <= regWrData[CTRL_LVL_HIGH_BIT];
			end else if (matchEvent[1]) begin
				toggle_out_high_pin <= !toggle_out_high_pin;
			end
			// Still toggles on the low match in 16-bit mode
			if (wrCtrl) begin
				toggle_out_low_pin <= regWrData[CTRL_LVL_LOW_BIT];
			end else if (matchEvent[0]) begin
				toggle_out_low_pin <= !toggle_out_low_pin;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Flags set by events; clear needs read-as-1, write 0, and a quiet signal in active mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_status_reg <= STAT_RST;
			statArm_reg <= STAT_RST;
		end else begin
			if (wrStat) begin
				// Enable and clear bits are plain read/write
				timer_status_reg[STAT_OVIEH_BIT] <= regWrData[STAT_OVIEH_BIT];
				timer_status_reg[STAT_CLRH_BIT] <= regWrData[STAT_CLRH_BIT];
				timer_status_reg[STAT_OVIEL_BIT] <= regWrData[STAT_OVIEL_BIT];
				timer_status_reg[STAT_CLRL_BIT] <= regWrData[STAT_CLRL_BIT];
				statArm_reg <= STAT_RST;
			end else if (regRdStb && regAddr == STAT_OFS) begin
				statArm_reg <= timer_status_reg;
			end
			timer_status_reg[STAT_WRAPH_BIT] <= wrapEvent[1]
				|| (timer_status_reg[STAT_WRAPH_BIT] && !(wrStat
				&& statArm_reg[STAT_WRAPH_BIT] && !regWrData[STAT_WRAPH_BIT]
				&& (subactiveMode || !wrapActive[1])));
			timer_status_reg[STAT_MATCHH_BIT] <= matchEvent[1]
				|| (timer_status_reg[STAT_MATCHH_BIT] && !(wrStat
				&& statArm_reg[STAT_MATCHH_BIT]
				&& !regWrData[STAT_MATCHH_BIT]
				&& (subactiveMode || !matchActive[1])));
			timer_status_reg[STAT_WRAPL_BIT] <= wrapEvent[0]
				|| (timer_status_reg[STAT_WRAPL_BIT] && !(wrStat
				&& statArm_reg[STAT_WRAPL_BIT] && !regWrData[STAT_WRAPL_BIT]
				&& (subactiveMode || !wrapActive[0])));
			timer_status_reg[STAT_MATCHL_BIT] <= matchEvent[0]
				|| (timer_status_reg[STAT_MATCHL_BIT] && !(wrStat
				&& statArm_reg[STAT_MATCHL_BIT]
				&& !regWrData[STAT_MATCHL_BIT]
				&& (subactiveMode || !matchActive[0])));
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests
	// ----------------------------------------------------------------
	// In active mode, requests set again while the source signal is still valid
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= IRQ_RST;
			irqHigh <= 1'b0;
			irqLow <= 1'b0;
		end else begin
			if (wrIrq) begin
				irq_reg[IRQ_ENL_BIT] <= regWrData[IRQ_ENL_BIT];
				irq_reg[IRQ_ENH_BIT] <= regWrData[IRQ_ENH_BIT];
			end
			irq_reg[IRQ_REQL_BIT] <= (srcActive[0] && !subactiveMode)
				|| srcEvent[0] || (irq_reg[IRQ_REQL_BIT]
				&& !(wrIrq && !regWrData[IRQ_REQL_BIT]));
			irq_reg[IRQ_REQH_BIT] <= (srcActive[1] && !subactiveMode)
				|| srcEvent[1] || (irq_reg[IRQ_REQH_BIT]
				&& !(wrIrq && !regWrData[IRQ_REQH_BIT]));
			irqLow <= irq_reg[IRQ_REQL_BIT] && irq_reg[IRQ_ENL_BIT];
			irqHigh <= irq_reg[IRQ_REQH_BIT] && irq_reg[IRQ_ENH_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Counter reads use the synchronised copy on the watch source in active mode
	always_comb begin
		case (regAddr)
			CTRL_OFS: readMux = timer_control_reg;
			STAT_OFS: readMux = timer_status_reg;
			CNT_HIGH_OFS: readMux = activeWatch[1] ? cntShadow_reg[15:8]
				: upper_counter;
			CNT_LOW_OFS: readMux = activeWatch[0] ? cntShadow_reg[7:0]
				: lower_counter;
			CMP_HIGH_OFS: readMux = upper_compare_reg;
			CMP_LOW_OFS: readMux = lower_compare_reg;
			IRQ_OFS: readMux = {4'h0, irq_reg};
			default: readMux = UNMAPPED_DATA;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData <= UNMAPPED_DATA;
		end else if (regRdStb) begin
			regRdData <= readMux;
		end else begin
			regRdData <= UNMAPPED_DATA;
		end
	end
endmodule // ctcl_timer

/* tb/ctcl_timer_sva.sv */
`timescale 1ns/1ns
// Port checker for the compare timer
module ctcl_timer_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [ctcl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ctcl_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic subactiveMode,
	input wire logic [ctcl_pkg::DATA_W-1:0] regRdData,
	input wire logic toggle_out_high_pin,
	input wire logic toggle_out_low_pin,
	input wire logic irqHigh,
	input wire logic irqLow
);
	import ctcl_pkg::*;
	logic [7:0] ctrl_reg; // Copy of the control register
	logic ctlWr; // Control write taken
	logic irqWr; // Request register write taken
	assign ctlWr = regWrStb && regAddr == CTRL_OFS;
	assign irqWr = regWrStb && regAddr == IRQ_OFS;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Control register shadow
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
		end else if (ctlWr) begin
			ctrl_reg <= regWrData;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
		else $error("read data not zero when idle");
	a_lvl_high_wins: assert property (ctlWr |=>
		toggle_out_high_pin == $past(regWrData[CTRL_LVL_HIGH_BIT]))
		else $error("high pin missed level bit");
	a_lvl_low_wins: assert property (ctlWr |=>
		toggle_out_low_pin == $past(regWrData[CTRL_LVL_LOW_BIT]))
		else $error("low pin missed level bit");
	a_hole_reads_zero: assert property (regRdStb && regAddr == 3'h7
		|=> regRdData == UNMAPPED_DATA) else $error("hole read not zero");
	a_irq_off_high: assert property (irqWr && !regWrData[IRQ_ENH_BIT]
		##1 !irqWr |=> !irqHigh) else $error("high request not masked");
	a_irq_off_low: assert property (irqWr && !regWrData[IRQ_ENL_BIT]
		##1 !irqWr |=> !irqLow) else $error("low request not masked");
	a_high_pin_still: assert property (!ctlWr && !$past(ctlWr) &&
		!ctrl_reg[CTRL_RUNL_BIT] && !ctrl_reg[CTRL_SPLIT_BIT]
		|=> $stable(toggle_out_high_pin)) else $error("high pin moved");
	a_low_pin_still: assert property (!ctlWr && !$past(ctlWr) &&
		!ctrl_reg[CTRL_RUNL_BIT] |=> $stable(toggle_out_low_pin))
		else $error("low pin moved while stopped");
	a_cnt_exact_sub: assert property (regWrStb && regAddr == CNT_LOW_OFS &&
		subactiveMode && !ctrl_reg[CTRL_RUNL_BIT] ##2 regRdStb &&
		regAddr == CNT_LOW_OFS |=> regRdData == $past(regWrData, 3))
		else $error("counter read not exact");
endmodule // ctcl_timer_sva
bind ctcl_timer ctcl_timer_sva u_sva (.ref_clk, .rst, .regAddr, .regWrData,
	.regWrStb, .regRdStb, .subactiveMode, .regRdData, .toggle_out_high_pin,
	.toggle_out_low_pin, .irqHigh, .irqLow);

/* tb/test_compare_timer_contention_logic.sv */
`timescale 1ns/1ns
// Self-checking bench for the compare timer
module test_compare_timer_contention_logic;
	import ctcl_pkg::*;
	`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
		$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
	logic ref_clk = 1'b0; // System clock
	logic rst = 1'b1; // Reset
	logic [ADDR_W-1:0] regAddr = 3'h0; // Register port
	logic [DATA_W-1:0] regWrData = 8'h00;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic watchClk = 1'b0; // Slow watch clock
	logic subactiveMode = 1'b0; // Operating mode
	logic [DATA_W-1:0] regRdData;
	logic toggle_out_high_pin, toggle_out_low_pin, irqHigh, irqLow;
	logic [3:0] watchDiv = 4'h0; // Watch clock divider
	logic [7:0] resetVal [8] = '{CTRL_RST, STAT_RST, CNT_RST, CNT_RST,
		CMP_RST, CMP_RST, {4'h0, IRQ_RST}, UNMAPPED_DATA};
	int n_errors = 0;
	int n_tests = 0;
	ctcl_timer dut (.ref_clk, .rst, .regAddr, .regWrData, .regWrStb,
		.regRdStb, .watchClk, .subactiveMode, .regRdData,
		.toggle_out_high_pin, .toggle_out_low_pin, .irqHigh, .irqLow);
	// ----------------------------------------
	// Clocks
	// ----------------------------------------
	always #10 ref_clk = ~ref_clk;
	// Watch clock period of 14 system cycles
	always @(posedge ref_clk) begin
		watchDiv <= (watchDiv == 4'h6) ? 4'h0 : watchDiv + 4'h1;
		if (watchDiv == 4'h6) watchClk <= ~watchClk;
	end
	// ----------------------------------------
	// Register port tasks
	// ----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask
	// Read and compare the masked data
	task automatic rd(input logic [2:0] a, input logic [7:0] m, e);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1;
		`CHK(regRdData & m, e)
	endtask
	// Wait n cycles, then step past the edge
	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic test_done;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog, about forty times the expected run
	initial begin
		#200000;
		n_errors++;
		test_done;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd(i[2:0], 8'hff, resetVal[i]);
		wr(STAT_OFS, 8'hff);
		rd(STAT_OFS, 8'hff, 8'h33);
		wr(STAT_OFS, 8'h00);
		// Control write drives both pins
		wr(CTRL_OFS, 8'h88);
		pause(1);
		`CHK({toggle_out_high_pin, toggle_out_low_pin}, 2'b11)
		wr(CTRL_OFS, 8'h00);
		// Active mode on the watch source refuses counter writes
		wr(CNT_LOW_OFS, 8'h5a);
		rd(CNT_LOW_OFS, 8'hff, 8'h00);
		// Exact counter access in subactive mode
		subactiveMode <= 1'b1;
		wr(CNT_LOW_OFS, 8'h5a);
		rd(CNT_LOW_OFS, 8'hff, 8'h5a);
		wr(CNT_LOW_OFS, 8'h00);
		subactiveMode <= 1'b0;
		// Split mode, lower half on system clock / 4
		wr(CMP_LOW_OFS, 8'h05);
		wr(CTRL_OFS, 8'h45);
		pause(60);
		`CHK(toggle_out_low_pin, 1'b1)
		rd(STAT_OFS, 8'h0c, 8'h04);
		wr(STAT_OFS, 8'h00);
		rd(STAT_OFS, 8'h04, 8'h00);
		wr(IRQ_OFS, 8'h05);
		pause(2);
		`CHK(irqLow, 1'b1)
		wr(IRQ_OFS, 8'h04);
		pause(2);
		`CHK(irqLow, 1'b0)
		// Lower half wraps
		wr(CNT_LOW_OFS, 8'hfe);
		pause(20);
		rd(STAT_OFS, 8'h08, 8'h08);
		// 16-bit mode, full match at 0x0006
		wr(CTRL_OFS, 8'h01);
		wr(CNT_HIGH_OFS, 8'h00);
		wr(CNT_LOW_OFS, 8'h00);
		wr(CMP_HIGH_OFS, 8'h00);
		wr(CMP_LOW_OFS, 8'h06);
		wr(CTRL_OFS, 8'h05);
		pause(50);
		`CHK(toggle_out_high_pin, 1'b1)
		rd(STAT_OFS, 8'h44, 8'h44);
		// Enable the upper request; its flag was set by the full match
		wr(IRQ_OFS, 8'h0a);
		pause(2);
		`CHK(irqHigh, 1'b1)
		test_done;
	end
endmodule // test_compare_timer_contention_logic
